// ==== hw/cpx_decode_end.sv ====
// halfword decoder: prefix pairing, immediates, base pc and issue interlocks
module cpx_decode_end
  import cpx_pkg::*;
  (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // link
  cpx_link_if.dec link,
  // status
  output logic interlockStall,
  output logic pairPending
);
  typedef enum logic [1:0] {
    PH_RUN,
    PH_SLOT,
    PH_WAIT_REDIR,
    PH_WAIT_BR
  } cpx_phase_e;

  typedef struct packed {
    cpx_phase_e phase;
    logic pairValid;
    logic pairIsCall;
    logic [HW_W-1:0] pairHw;
    logic [PC_W-1:0] pairPc;
    logic [PC_W-1:0] slotBase;
    logic loadValid;
    logic [2:0] loadReg;
    logic [1:0] mdGuard;
    logic opValid;
    logic [HW_W-1:0] opHw;
    logic [HW_W-1:0] opPairHw;
    logic [PC_W-1:0] opPc;
    logic [PC_W-1:0] opBasePc;
    logic [15:0] opImm;
    logic [5:0] opShamt;
    logic opExt;
    logic opInSlot;
    logic opIsBranch;
    logic opIsJump;
    logic stall;
  } cpx_dec_s;

  cpx_dec_s st_reg;
  cpx_dec_s st_next;
  logic qValid;
  cpx_entry_s qData;
  logic qPop;
  logic qFlush;
  logic [15:0] hw;
  logic ext;
  logic jumpNow;

  // ==========================================================================
  // immediate and shift count shaping
  function automatic logic [15:0] immOf(input logic [15:0] h,
                                        input logic e,
                                        input logic [10:0] p);
    logic [15:0] r;
    r = {8'h00, h[7:0]};
    if (e) begin
      if (h[15:11] == OP_RRIA) begin
        r = {p[3], p[3:0], p[10:4], h[3:0]};
      end else begin
        r = {p[4:0], p[10:5], h[4:0]};
      end
    end else if (h[15:11] == OP_RRIA) begin
      r = {{12{h[3]}}, h[3:0]};
    end else if (h[15:11] == OP_LW) begin
      r = {9'h000, h[4:0], 2'h0};
    end
    return r;
  endfunction : immOf

  function automatic logic [5:0] shamtOf(input logic [15:0] h,
                                         input logic e,
                                         input logic [10:0] p);
    logic [5:0] r;
    logic [2:0] c;
    r = 6'h00;
    c = (h[15:11] == OP_SHIFT) ? h[4:2] : h[10:8];
    if (h[15:11] == OP_SHIFT ||
        (h[15:11] == OP_RR && (h[4:0] == RR_DSRL || h[4:0] == RR_DSRA))) begin
      if (!e) begin
        r = (c == 3'h0) ? SHIFT_ZERO_COUNT : {3'h0, c};
      end else if (h[15:11] == OP_SHIFT && h[1:0] != SH_DSLL) begin
        r = {1'b0, p[10:6]};
      end else begin
        r = {p[5], p[10:6]};
      end
    end
    return r;
  endfunction : shamtOf

  // ==========================================================================
  // input queue
  cpx_hw_queue u_queue (
    .clk(clk),
    .sys_rst(sys_rst),
    .flush(qFlush),
    .inValid(link.hwValid),
    .inData({link.hwPc, link.hwData}),
    .inReady(link.hwReady),
    .outValid(qValid),
    .outData(qData),
    .outReady(qPop)
  );

  // ==========================================================================
  // issue logic
  always_comb begin
    st_next = st_reg;
    st_next.opValid = 1'b0;
    st_next.stall = 1'b0;
    st_next.loadValid = 1'b0;
    st_next.mdGuard = (st_reg.mdGuard != 2'h0) ?
      st_reg.mdGuard - 2'h1 : 2'h0;
    qPop = 1'b0;
    qFlush = 1'b0;
    hw = qData.hw;
    ext = st_reg.pairValid && !st_reg.pairIsCall;
    jumpNow = 1'b0;
    if (st_reg.phase == PH_WAIT_BR) begin
      if (link.brDone) begin
        st_next.phase = PH_RUN;
        if (link.brTaken) begin
          // drop whatever followed the branch, whole pairs included
          qFlush = 1'b1;
          st_next.pairValid = 1'b0;
          st_next.pairIsCall = 1'b0;
        end
      end
    end else if (st_reg.phase == PH_WAIT_REDIR) begin
      if (link.redirect) begin
        st_next.phase = PH_RUN;
        qFlush = 1'b1;
        st_next.pairValid = 1'b0;
        st_next.pairIsCall = 1'b0;
      end
    end else if (qValid) begin
      if (st_reg.loadValid && hw[15:11] != OP_EXTEND && !st_reg.pairIsCall &&
          (hw[10:8] == st_reg.loadReg || hw[7:5] == st_reg.loadReg)) begin
        // conservative match on both register fields; costs a stray bubble
        st_next.stall = 1'b1;
      end else if (isMdRead(hw) &&
                   (link.mdBusy || st_reg.mdGuard != 2'h0)) begin
        st_next.stall = 1'b1;
      end else begin
        qPop = 1'b1;
        if (!st_reg.pairValid && hw[15:11] == OP_EXTEND) begin
          // hold the prefix; pairing is by order, not by word alignment
          st_next.pairValid = 1'b1;
          st_next.pairIsCall = 1'b0;
          st_next.pairHw = hw;
          st_next.pairPc = qData.pc;
        end else if (!st_reg.pairValid && hw[15:11] == OP_JAL) begin
          st_next.pairValid = 1'b1;
          st_next.pairIsCall = 1'b1;
          st_next.pairHw = hw;
          st_next.pairPc = qData.pc;
        end else begin
          // a stale call mark would turn every later op into a jump
          st_next.pairValid = 1'b0;
          st_next.pairIsCall = 1'b0;
          st_next.opValid = 1'b1;
          st_next.opHw = hw;
          st_next.opPairHw = st_reg.pairValid ? st_reg.pairHw : 16'h0000;
          st_next.opPc = st_reg.pairValid ? st_reg.pairPc : qData.pc;
          st_next.opExt = ext;
          st_next.opImm = immOf(hw, ext, st_reg.pairHw[10:0]);
          st_next.opShamt = shamtOf(hw, ext, st_reg.pairHw[10:0]);
          st_next.opInSlot = st_reg.phase == PH_SLOT;
          // one base serves both address math and exception return
          if (st_reg.pairValid) begin
            st_next.opBasePc = st_reg.pairPc;
          end else if (st_reg.phase == PH_SLOT) begin
            st_next.opBasePc = st_reg.slotBase;
          end else begin
            st_next.opBasePc = qData.pc;
          end
          jumpNow = st_reg.pairIsCall || isRegJump(hw);
          st_next.opIsJump = jumpNow;
          st_next.opIsBranch = isBranch(hw) && !st_reg.pairIsCall;
          st_next.loadValid = isLoad(hw) && !st_reg.pairIsCall;
          st_next.loadReg = loadDest(hw);
          if (isMdWrite(hw)) begin
            st_next.mdGuard = MD_HANDOFF;
          end
          if (st_reg.phase == PH_SLOT) begin
            // slot done; nothing more issues until the target arrives
            st_next.phase = PH_WAIT_REDIR;
          end else if (jumpNow) begin
            st_next.phase = PH_SLOT;
            st_next.slotBase = st_reg.pairIsCall ?
              st_reg.pairPc : qData.pc;
          end else if (st_next.opIsBranch) begin
            // no branch slot: hold the follower until the outcome is known
            st_next.phase = PH_WAIT_BR;
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= '0;
      st_reg.phase <= PH_RUN;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // outputs
  assign link.opValid = st_reg.opValid;
  assign link.opHw = st_reg.opHw;
  assign link.opPairHw = st_reg.opPairHw;
  assign link.opPc = st_reg.opPc;
  assign link.opBasePc = st_reg.opBasePc;
  assign link.opImm = st_reg.opImm;
  assign link.opShamt = st_reg.opShamt;
  assign link.opExt = st_reg.opExt;
  assign link.opInSlot = st_reg.opInSlot;
  assign link.opIsBranch = st_reg.opIsBranch;
  assign link.opIsJump = st_reg.opIsJump;
  assign interlockStall = st_reg.stall;
  assign pairPending = st_reg.pairValid;
endmodule : cpx_decode_end

// ==== hw/cpx_pkg.sv ====
// shared constants, entry layout and decode helpers for the compact isa path
package cpx_pkg;

  // ==========================================================================
  // widths
  localparam int HW_W = 16;
  localparam int PC_W = 64;
  localparam int ENTRY_W = PC_W + HW_W;
  localparam logic [1:0] Q_DEPTH = 2'h2;
  localparam logic [PC_W-1:0] PC_RESET = 64'h0000_0000_0000_0000;

  // ==========================================================================
  // major opcodes, halfword bits 15:11
  localparam logic [4:0] OP_ADDIUPC = 5'h01;
  localparam logic [4:0] OP_B = 5'h02;
  localparam logic [4:0] OP_JAL = 5'h03;
  localparam logic [4:0] OP_BEQZ = 5'h04;
  localparam logic [4:0] OP_BNEZ = 5'h05;
  localparam logic [4:0] OP_SHIFT = 5'h06;
  localparam logic [4:0] OP_LD = 5'h07;
  localparam logic [4:0] OP_RRIA = 5'h08;
  localparam logic [4:0] OP_I8 = 5'h0C;
  localparam logic [4:0] OP_LWSP = 5'h12;
  localparam logic [4:0] OP_LW = 5'h13;
  localparam logic [4:0] OP_LWPC = 5'h16;
  localparam logic [4:0] OP_RR = 5'h1D;
  localparam logic [4:0] OP_EXTEND = 5'h1E;
  localparam logic [4:0] OP_I64 = 5'h1F;

  // ==========================================================================
  // minor codes
  localparam logic [4:0] RR_JALR = 5'h00;
  localparam logic [4:0] RR_DSRL = 5'h08;
  localparam logic [4:0] RR_MFUP = 5'h10;
  localparam logic [4:0] RR_MFLO = 5'h12;
  localparam logic [4:0] RR_DSRA = 5'h13;
  localparam logic [1:0] RR_MD_GROUP = 2'h3;
  localparam logic [1:0] SH_DSLL = 2'h1;
  localparam logic [1:0] I8_BR_GROUP = 2'h0;
  localparam logic [2:0] I64_LDSP = 3'h0;
  localparam logic [2:0] I64_LDPC = 3'h4;
  localparam logic [2:0] I64_DADDIUPC = 3'h6;

  // ==========================================================================
  // timing counts
  localparam logic [5:0] SHIFT_ZERO_COUNT = 6'h08;
  localparam logic [1:0] MD_HANDOFF = 2'h3;
  localparam logic [1:0] MD_READ_GAP = 2'h2;
  localparam logic [PC_W-1:0] HW_BYTES = 64'h0000_0000_0000_0002;

  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic [HW_W-1:0] hw;
  } cpx_entry_s;

  // ==========================================================================
  // decode helpers
  function automatic logic isBranch(input logic [15:0] hw);
    return hw[15:11] == OP_B || hw[15:11] == OP_BEQZ ||
      hw[15:11] == OP_BNEZ ||
      (hw[15:11] == OP_I8 && hw[10:9] == I8_BR_GROUP);
  endfunction : isBranch

  function automatic logic isRegJump(input logic [15:0] hw);
    return hw[15:11] == OP_RR && hw[4:0] == RR_JALR;
  endfunction : isRegJump

  function automatic logic isLoad(input logic [15:0] hw);
    return hw[15:11] == OP_LD || hw[15:14] == 2'h2 ||
      (hw[15:11] == OP_I64 && (hw[10:8] == I64_LDSP || hw[10:8] == I64_LDPC));
  endfunction : isLoad

  function automatic logic [2:0] loadDest(input logic [15:0] hw);
    return (hw[15:11] == OP_LWSP || hw[15:11] == OP_LWPC) ? hw[10:8] : hw[7:5];
  endfunction : loadDest

  function automatic logic isPcRel(input logic [15:0] hw);
    return hw[15:11] == OP_ADDIUPC || hw[15:11] == OP_LWPC ||
      (hw[15:11] == OP_I64 &&
       (hw[10:8] == I64_LDPC || hw[10:8] == I64_DADDIUPC));
  endfunction : isPcRel

  function automatic logic isMdRead(input logic [15:0] hw);
    return hw[15:11] == OP_RR && (hw[4:0] == RR_MFUP || hw[4:0] == RR_MFLO);
  endfunction : isMdRead

  function automatic logic isMdWrite(input logic [15:0] hw);
    return hw[15:11] == OP_RR && hw[4:3] == RR_MD_GROUP;
  endfunction : isMdWrite

endpackage : cpx_pkg

// ==== hw/cpx_link_if.sv ====
// link between the halfword decoder and the fetch/execute side
interface cpx_link_if
  import cpx_pkg::*;
  ();
  // halfword stream, fetch to decoder
  logic hwValid;
  logic hwReady;
  logic [HW_W-1:0] hwData;
  logic [PC_W-1:0] hwPc;
  // issued operation, decoder to execute
  logic opValid;
  logic [HW_W-1:0] opHw;
  logic [HW_W-1:0] opPairHw;
  logic [PC_W-1:0] opPc;
  logic [PC_W-1:0] opBasePc;
  logic [15:0] opImm;
  logic [5:0] opShamt;
  logic opExt;
  logic opInSlot;
  logic opIsBranch;
  logic opIsJump;
  // resolution and status, execute to decoder
  logic brDone;
  logic brTaken;
  logic redirect;
  logic mdBusy;

  modport dec (
    input hwValid, hwData, hwPc, brDone, brTaken, redirect, mdBusy,
    output hwReady, opValid, opHw, opPairHw, opPc, opBasePc, opImm,
    output opShamt, opExt, opInSlot, opIsBranch, opIsJump
  );
  modport exe (
    output hwValid, hwData, hwPc, brDone, brTaken, redirect, mdBusy,
    input hwReady, opValid, opHw, opPairHw, opPc, opBasePc, opImm,
    input opShamt, opExt, opInSlot, opIsBranch, opIsJump
  );
endinterface : cpx_link_if

// ==== hw/cpx_hw_queue.sv ====
// two-entry halfword queue with registered valid, data and ready
module cpx_hw_queue
  import cpx_pkg::*;
  (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic flush,
  // filling side
  input wire logic inValid,
  input wire cpx_entry_s inData,
  output logic inReady,
  // draining side
  output logic outValid,
  output cpx_entry_s outData,
  input wire logic outReady
);
  typedef struct packed {
    cpx_entry_s [1:0] mem;
    logic [1:0] cnt;
    logic valid;
    logic ready;
  } cpx_q_s;

  cpx_q_s st_reg;
  cpx_q_s st_next;
  logic push;
  logic pop;
  logic [1:0] slot;

  // ==========================================================================
  // next state
  always_comb begin
    st_next = st_reg;
    pop = st_reg.valid && outReady;
    push = inValid && st_reg.ready;
    slot = pop ? st_reg.cnt - 2'h1 : st_reg.cnt;
    // flush wins so a stale halfword caught in flight is dropped
    if (flush) begin
      st_next.cnt = 2'h0;
    end else begin
      if (pop) begin
        st_next.mem[0] = st_reg.mem[1];
      end
      if (push) begin
        st_next.mem[slot[0]] = inData;
      end
      st_next.cnt = slot + {1'b0, push};
    end
    st_next.valid = st_next.cnt != 2'h0;
    // ready looks at the next count, so a full queue never takes a word
    st_next.ready = st_next.cnt < Q_DEPTH;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= '0;
      st_reg.ready <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign inReady = st_reg.ready;
  assign outValid = st_reg.valid;
  assign outData = st_reg.mem[0];
endmodule : cpx_hw_queue

// ==== hw/cpx_exec_end.sv ====
// fetch/execute side: feeds halfwords, resolves branches, ends jump slots
module cpx_exec_end
  import cpx_pkg::*;
  (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // link
  cpx_link_if.exe link,
  // fetch stream
  input wire logic fetchValid,
  input wire logic [HW_W-1:0] fetchHw,
  input wire logic [PC_W-1:0] fetchPc,
  output logic fetchReady,
  output logic fetchFlush,
  // issued operations
  output logic exValid,
  output logic [HW_W-1:0] exHw,
  output logic [HW_W-1:0] exPairHw,
  output logic [PC_W-1:0] exPc,
  output logic [PC_W-1:0] exBasePc,
  output logic [15:0] exImm,
  output logic [5:0] exShamt,
  output logic exExt,
  // execute status
  input wire logic exBrDone,
  input wire logic exBrTaken,
  input wire logic exMdBusy,
  output logic swHazard
);
  typedef enum logic [1:0] {
    EX_RUN,
    EX_SLOT,
    EX_BRANCH
  } cpx_ex_e;

  typedef struct packed {
    cpx_ex_e phase;
    logic [1:0] mdWindow;
    logic brDone;
    logic brTaken;
    logic redirect;
    logic mdBusy;
    logic flush;
    logic valid;
    logic [HW_W-1:0] hw;
    logic [HW_W-1:0] pairHw;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] relative_base_pc;
    logic [15:0] imm;
    logic [5:0] shamt;
    logic ext;
    logic hazard;
  } cpx_ex_s;

  cpx_ex_s st_reg;
  cpx_ex_s st_next;
  cpx_entry_s qOut;
  logic qFlush;

  cpx_hw_queue u_queue (
    .clk(clk),
    .sys_rst(sys_rst),
    .flush(qFlush),
    .inValid(fetchValid),
    .inData({fetchPc, fetchHw}),
    .inReady(fetchReady),
    .outValid(link.hwValid),
    .outData(qOut),
    .outReady(link.hwReady)
  );

  // ==========================================================================
  // resolution
  always_comb begin
    st_next = st_reg;
    st_next.brDone = 1'b0;
    st_next.redirect = 1'b0;
    st_next.flush = 1'b0;
    st_next.hazard = 1'b0;
    st_next.mdBusy = exMdBusy;
    st_next.valid = link.opValid;
    qFlush = 1'b0;
    if (link.opValid) begin
      st_next.hw = link.opHw;
      st_next.pairHw = link.opPairHw;
      st_next.pc = link.opPc;
      st_next.relative_base_pc = link.opBasePc;
      st_next.imm = link.opImm;
      st_next.shamt = link.opShamt;
      st_next.ext = link.opExt;
      if (st_reg.mdWindow != 2'h0) begin
        st_next.mdWindow = st_reg.mdWindow - 2'h1;
        st_next.hazard = isMdWrite(link.opHw);
      end
      if (isMdRead(link.opHw)) begin
        st_next.mdWindow = MD_READ_GAP;
      end
    end
    if (st_reg.phase == EX_BRANCH) begin
      if (exBrDone) begin
        st_next.phase = EX_RUN;
        st_next.brDone = 1'b1;
        st_next.brTaken = exBrTaken;
        qFlush = exBrTaken;
        st_next.flush = exBrTaken;
      end
    end else if (link.opValid) begin
      if (st_reg.phase == EX_SLOT) begin
        st_next.phase = EX_RUN;
        st_next.redirect = 1'b1;
        st_next.flush = 1'b1;
        qFlush = 1'b1;
        // flags software that broke the slot restrictions
        st_next.hazard = link.opExt || link.opIsBranch ||
          link.opIsJump;
      end else if (link.opIsJump) begin
        st_next.phase = EX_SLOT;
      end else if (link.opIsBranch) begin
        st_next.phase = EX_BRANCH;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= '0;
      st_reg.phase <= EX_RUN;
    end else begin
      st_reg <= st_next;
    end
  end

  assign link.hwData = qOut.hw;
  assign link.hwPc = qOut.pc;
  assign link.brDone = st_reg.brDone;
  assign link.brTaken = st_reg.brTaken;
  assign link.redirect = st_reg.redirect;
  assign link.mdBusy = st_reg.mdBusy;
  assign fetchFlush = st_reg.flush;
  assign exValid = st_reg.valid;
  assign exHw = st_reg.hw;
  assign exPairHw = st_reg.pairHw;
  assign exPc = st_reg.pc;
  assign exBasePc = st_reg.relative_base_pc;
  assign exImm = st_reg.imm;
  assign exShamt = st_reg.shamt;
  assign exExt = st_reg.ext;
  assign swHazard = st_reg.hazard;
endmodule : cpx_exec_end

// ==== verification/cpx_link_checker.sv ====
// assertion checker for the decoder-to-execute link
module cpx_link_checker
  import cpx_pkg::*;
  (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // issued operation
  input wire logic opValid,
  input wire logic [HW_W-1:0] opHw,
  input wire logic [HW_W-1:0] opPairHw,
  input wire logic [PC_W-1:0] opPc,
  input wire logic [PC_W-1:0] opBasePc,
  input wire logic [15:0] opImm,
  input wire logic [5:0] opShamt,
  input wire logic opExt,
  input wire logic opInSlot,
  input wire logic opIsBranch,
  input wire logic opIsJump,
  // resolution and status
  input wire logic brDone,
  input wire logic brTaken,
  input wire logic mdBusy
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================================
  // helpers
  logic [PC_W-1:0] jmpPc_reg;
  wire logic isShift = opValid && opHw[15:11] == OP_SHIFT;
  wire logic mdW = opHw[15:11] == OP_RR && opHw[4:3] == 2'h3;
  wire logic mdR = opHw[15:11] == OP_RR &&
    (opHw[4:0] == RR_MFUP || opHw[4:0] == RR_MFLO);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      jmpPc_reg <= PC_RESET;
    end else if (opValid && opIsJump) begin
      jmpPc_reg <= opPc;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ==========================================================================
  // properties
  base_plain_a: assert property (
    opValid && !opExt && !opInSlot |-> opBasePc == opPc)
    else $error("plain op base pc wrong");
  base_ext_a: assert property (
    opValid && opExt |-> opBasePc == opPc) else $error("ext base pc wrong");
  slot_base_a: assert property (
    opValid && opInSlot |-> opBasePc == jmpPc_reg)
    else $error("slot base pc wrong");
  pair_prefix_a: assert property (
    opValid && opExt |-> opPairHw[15:11] == OP_EXTEND)
    else $error("extended op without prefix");
  lw_scale_a: assert property (
    opValid && !opExt && opHw[15:11] == OP_LW |->
    opImm == {9'h000, opHw[4:0], 2'h0}) else $error("lw offset wrong");
  rria_ext_a: assert property (
    opValid && opExt && opHw[15:11] == OP_RRIA |->
    opImm == {opPairHw[3], opPairHw[3:0], opPairHw[10:4], opHw[3:0]})
    else $error("rri-a immediate wrong");
  shift_ext_a: assert property (
    isShift && opExt && opHw[1:0] != SH_DSLL |->
    opShamt == {1'h0, opPairHw[10:6]}) else $error("shift count wrong");
  dshift_ext_a: assert property (
    isShift && opExt && opHw[1:0] == SH_DSLL |->
    opShamt == {opPairHw[5], opPairHw[10:6]}) else $error("dsll count wrong");
  branch_hold_a: assert property (
    opValid && opIsBranch |=> !opValid) else $error("issue before outcome");
  taken_cancel_a: assert property (
    brDone && brTaken |=> (!opValid) [*2]) else $error("follower issued");
  md_guard_a: assert property (
    opValid && mdW |=> (!(opValid && mdR)) [*3])
    else $error("result read too soon");
  md_busy_a: assert property (
    opValid && mdR |-> !$past(mdBusy)) else $error("result read while busy");
endmodule : cpx_link_checker

// ==== verification/cpx_compact_isa_prefix_and_slot_control_tb.sv ====
// self-checking bench for the decoder and execute ends joined by the link
module cpx_compact_isa_prefix_and_slot_control_tb
  import cpx_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================================
  // signals
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic fetchValid = 1'h0;
  logic [HW_W-1:0] fetchHw = 16'h0000;
  logic [PC_W-1:0] fetchPc = 64'h0;
  logic exBrDone = 1'h0;
  logic exBrTaken = 1'h0;
  logic exMdBusy = 1'h0;
  logic fetchReady, fetchFlush, exValid, exExt, swHazard;
  logic interlockStall, pairPending;
  logic [HW_W-1:0] exHw, exPairHw;
  logic [PC_W-1:0] exPc, exBasePc;
  logic [15:0] exImm;
  logic [5:0] exShamt;
  int badCount = 0;
  int numChecks = 0;
  int stalls = 0;
  int hazards = 0;
  int mdLeft = 0;
  int flushes = 0;
  bit tk = 0;
  logic [15:0] lfsr = 16'h0011;
  logic [15:0] prog[$];
  logic [15:0] ops[$];
  logic [159:0] expQ[$];
  logic [159:0] e;

  cpx_link_if cpx_link_if_inst ();
  cpx_decode_end cpx_decode_end_inst (.clk, .sys_rst,
    .link(cpx_link_if_inst), .interlockStall, .pairPending);
  cpx_exec_end cpx_exec_end_inst (.clk, .sys_rst, .link(cpx_link_if_inst),
    .fetchValid, .fetchHw, .fetchPc, .fetchReady, .fetchFlush, .exValid,
    .exHw, .exPairHw, .exPc, .exBasePc, .exImm, .exShamt, .exExt,
    .exBrDone, .exBrTaken, .exMdBusy, .swHazard);
  cpx_link_checker cpx_link_checker_inst (.clk, .sys_rst,
    .opValid(cpx_link_if_inst.opValid), .opHw(cpx_link_if_inst.opHw),
    .opPairHw(cpx_link_if_inst.opPairHw), .opPc(cpx_link_if_inst.opPc),
    .opBasePc(cpx_link_if_inst.opBasePc), .opImm(cpx_link_if_inst.opImm),
    .opShamt(cpx_link_if_inst.opShamt), .opExt(cpx_link_if_inst.opExt),
    .opInSlot(cpx_link_if_inst.opInSlot),
    .opIsBranch(cpx_link_if_inst.opIsBranch),
    .opIsJump(cpx_link_if_inst.opIsJump),
    .brDone(cpx_link_if_inst.brDone), .brTaken(cpx_link_if_inst.brTaken),
    .mdBusy(cpx_link_if_inst.mdBusy));

  initial begin
    forever #12.5 clk = ~clk;
  end

  // ==========================================================================
  // helpers
  function automatic logic [15:0] nextRand(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nextRand

  task automatic check(input logic [159:0] s, input logic [159:0] x);
    numChecks++;
    if (s !== x) begin
      badCount++;
      $display("unexpected at %0t: saw %0h want %0h", $time, s, x);
    end
  endtask : check

  task automatic testDone();
    $display("checks %0d mismatches %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : testDone

  task automatic fill(input int n);
    repeat (n) begin
      lfsr = nextRand(lfsr);
      prog.push_back({5'h0D, lfsr[10:0]});
    end
  endtask : fill

  // model walks the stream, then the stream is offered to fetch
  task automatic run(input string nm, input logic [63:0] pc0, input bit take);
    logic [63:0] pc, pp, jp;
    logic [15:0] pre;
    bit hasPre, slot, stop, rdy;
    int f0;
    pc = pc0;
    hasPre = 0;
    slot = 0;
    stop = 0;
    tk = take;
    f0 = flushes;
    foreach (prog[i]) begin
      if (stop) break;
      if (!hasPre && (prog[i][15:11] == OP_EXTEND ||
          prog[i][15:11] == OP_JAL)) begin
        pre = prog[i];
        pp = pc;
        hasPre = 1;
      end else begin
        expQ.push_back({prog[i], hasPre ? pre : 16'h0000, hasPre ? pp : pc,
          slot ? jp : hasPre ? pp : pc});
        stop = slot || (take && prog[i][15:11] == OP_BEQZ);
        slot = (prog[i][15:11] == OP_RR && prog[i][4:0] == 5'h00) ||
          (hasPre && pre[15:11] == OP_JAL);
        jp = hasPre ? pp : pc;
        hasPre = 0;
      end
      pc += 64'h2;
    end
    foreach (prog[i]) begin
      fetchValid = 1'h1;
      fetchHw = prog[i];
      fetchPc = pc0 + 64'(2 * i);
      do begin
        rdy = fetchReady;
        @(posedge clk);
        #1;
      end while (!rdy && !fetchFlush);
      if (fetchFlush) break;
    end
    fetchValid = 1'h0;
    for (int n = 0; n < 80 && expQ.size() != 0; n++) @(posedge clk);
    repeat (8) @(posedge clk);
    #1;
    check(expQ.size(), 0);
    check(flushes - f0, stop);
    check(pairPending, 0);
    prog.delete();
    $display("%s finished", nm);
  endtask : run

  // ==========================================================================
  // execute-side responder and result compare
  always @(posedge clk) begin
    #1;
    stalls += interlockStall;
    hazards += swHazard;
    flushes += fetchFlush;
    exBrDone = exValid && exHw[15:11] == OP_BEQZ;
    exBrTaken = tk;
    if (exValid && exHw[15:11] == OP_RR && exHw[4:3] == 2'h3) mdLeft = 5;
    if (exValid && exHw[15:11] == OP_RR && exHw[4:0] == RR_MFUP)
      check(mdLeft, 0);
    exMdBusy = mdLeft != 0;
    if (mdLeft != 0) mdLeft--;
    if (exValid) begin
      e = expQ.size() != 0 ? expQ.pop_front() : 160'h0;
      check({exHw, exPairHw, exPc, exBasePc}, e);
      check(exExt, e[143:139] == OP_EXTEND);
      if (exExt && exHw[15:11] != OP_SHIFT && exHw[15:11] != OP_RRIA &&
          exHw[15:11] != OP_RR)
        check(exImm, {exPairHw[4:0], exPairHw[10:5], exHw[4:0]});
      if (exExt && exHw[15:11] == OP_SHIFT)
        check(exShamt,
          {exHw[1:0] == SH_DSLL && exPairHw[5], exPairHw[10:6]});
    end
  end

  initial begin
    #200000;
    badCount++;
    testDone();
  end

  // ==========================================================================
  // scenarios
  initial begin
    repeat (6) @(posedge clk);
    #1 sys_rst = 1'h0;
    prog = '{16'hB105, 16'h0A7F, 16'hFC23, 16'hFE5F};
    fill(4);
    run("relative", 64'h1000, 0);
    ops = '{16'hB105, 16'h0A7F, 16'hFC23, 16'hFE5F, 16'h3140,
      16'h3141, 16'h9A44, 16'h414B};
    foreach (ops[i]) begin
      lfsr = nextRand(lfsr);
      prog.push_back({OP_EXTEND, lfsr[10:6],
        ops[i][15:11] != OP_SHIFT ? lfsr[5:0] :
        {ops[i][1:0] == SH_DSLL && lfsr[5], 5'h00}});
      prog.push_back(ops[i]);
    end
    run("extended", 64'h2006, 0);
    prog = '{16'hE900, 16'hB105, 16'h6801, 16'h6802};
    run("register jump", 64'h3000, 0);
    prog = '{16'h1810, 16'h1234, 16'h0A7F, 16'h6801};
    run("call", 64'h4002, 0);
    prog = '{16'h2110, 16'h6803, 16'h6804};
    run("taken branch", 64'h5000, 1);
    prog = '{16'h2110, 16'h2208, 16'hF0A3, 16'hB105, 16'hE900, 16'h0A7F,
      16'h6801};
    run("branch followers", 64'h6000, 0);
    stalls = 0;
    prog = '{16'h9844, 16'hE271};
    fill(2);
    run("load use", 64'h7000, 0);
    check(stalls, 1);
    prog = '{16'hE958, 16'hEB10, 16'hE958};
    fill(2);
    run("result read", 64'h8000, 0);
    check(hazards, 1);
    testDone();
  end
endmodule : cpx_compact_isa_prefix_and_slot_control_tb
